/* File: rtl/csdr_card_specific_data.sv */
// Purpose : Card specific data register with fixed and programmable cells
// Assumes : Program request is one cycle, image supplied whole by host
// Notes   : A program attempt that alters fixed or spent cells is refused
`timescale 1ns/1ps
`default_nettype none
module csdr_card_specific_data
    import csdr_pkg::*;
#(
    parameter logic [127:0] FIXED_IMAGE = 128'h0000_0000_0000_0000_0000_0000_0000_0001
) (
    input  wire logic        ref_clk,       // Card clock
    input  wire logic        arst_n,        // Async reset, active low
    input  wire csdr_prog_t  prog,          // Program command
    output logic [127:0]     csd_value,     // Register contents
    output csdr_flags_t      flags,         // Decoded control flags
    output logic [15:0]      nac_max_cyc,   // Clocked access bound in cycles
    output logic             prog_done,     // Program accepted, one cycle
    output logic             prog_error     // Program refused, one cycle
);

    // =========================================================
    // Storage
    // =========================================================
    logic [127:0] prog_r;       // Programmable cells
    logic [127:0] prog_nxt;
    logic [127:0] written_r;    // Once-writable cells already written
    logic [127:0] written_nxt;
    logic [127:0] image;        // Register view
    logic [127:0] fixed_view;   // Fixed part, reserved bits cleared
    logic         bad_fixed;    // Attempt to change a fixed cell
    logic         bad_once;     // Attempt to rewrite a spent cell

    // Fixed cells with reserved positions forced to zero
    assign fixed_view = FIXED_IMAGE & ~(CSDR_MULTI_MASK | CSDR_ONCE_MASK |
                        CSDR_RSV_MASK | CSDR_BYTE7_MASK | CSDR_ONE_MASK); // R21

    // Full view: fixed, programmable, bit zero one
    assign image = fixed_view | prog_r | CSDR_ONE_MASK; // R5

    // =========================================================
    // Program checking
    // =========================================================
    // Fixed or reserved cell changed by request
    assign bad_fixed = |((prog.data ^ image) &
                         ~(CSDR_MULTI_MASK | CSDR_ONCE_MASK | CSDR_ONE_MASK)); // R3

    // Once cell changed after it was written
    assign bad_once = |((prog.data ^ image) & CSDR_ONCE_MASK & written_r); // R4

    // Next programmable value
    always_comb begin
        prog_nxt    = prog_r;
        written_nxt = written_r;
        if (prog.valid && !bad_fixed && !bad_once) begin
            // Only programmable cells taken
            prog_nxt    = prog.data & (CSDR_MULTI_MASK | CSDR_ONCE_MASK); // R3
            written_nxt = written_r | CSDR_ONCE_MASK; // R4
        end
    end

    // Programmable cells
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prog_r <= CSDR_RESET_IMAGE & (CSDR_MULTI_MASK | CSDR_ONCE_MASK);
        end else begin
            prog_r <= prog_nxt; // R4
        end
    end

    // Once-write bookkeeping
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            written_r <= CSDR_NO_WRITTEN;
        end else begin
            written_r <= written_nxt;
        end
    end

    // =========================================================
    // Outputs
    // =========================================================
    // Register image, fields at fixed slices
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            csd_value <= CSDR_ONE_MASK;
        end else begin
            csd_value <= image; // R1 R2 R7 R8 R11 R12 R16 R17 R18 R6
        end
    end

    // Decoded flags for the card core
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            flags <= '0;
        end else begin
            flags.partial_read_allowed    <= image[CSDR_RPART_BIT]; // R14
            flags.partial_write_allowed   <= image[CSDR_WPART_BIT]; // R17
            flags.write_cross_boundary_ok <= image[CSDR_WMIS_BIT]; // R15
            flags.read_cross_boundary_ok  <= image[CSDR_RMIS_BIT]; // R20
            flags.permanent_lock          <= image[CSDR_PERM_BIT];
            flags.temporary_lock          <= image[CSDR_TEMP_BIT];
            flags.max_read_block_length   <= image[CSDR_RBL_MSB:CSDR_RBL_LSB]; // R13
            flags.max_write_block_length  <= image[CSDR_WBL_MSB:CSDR_WBL_LSB];
            flags.clocked_access_time     <= image[CSDR_CLOCKED_ACCESS_TIME_MSB:CSDR_CLOCKED_ACCESS_TIME_LSB];
        end
    end

    // Clocked access bound, code times one hundred
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            nac_max_cyc <= 16'h0000;
        end else begin
            nac_max_cyc <= 16'(image[CSDR_CLOCKED_ACCESS_TIME_MSB:CSDR_CLOCKED_ACCESS_TIME_LSB] * CSDR_CLOCKED_ACCESS_TIME_UNIT_CYC); // R9
        end
    end

    // Outcome pulses
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prog_done  <= 1'b0;
            prog_error <= 1'b0;
        end else begin
            prog_done  <= prog.valid && !bad_fixed && !bad_once;
            prog_error <= prog.valid && (bad_fixed || bad_once); // R21
        end
    end

    // Host adds async part at its own rate (R10); it recomputes checksum (R19)

endmodule : csdr_card_specific_data
`default_nettype wire

/* File: rtl/csdr_pkg.sv */
// Purpose : Constants, field layout and types of the card specific data register
// Assumes : 128-bit register, bit 127 sent first, fixed content set by parameter
// Notes   : Programmable cells change only through the program command port
//
// How it works
// R1 - Two-bit structure version at top, read only
// R2 - Four-bit spec version code, read only
// R3 - Only program command alters programmable cells
// R4 - Temporary lock, ecc, checksum rewritable; others once
// R5 - Bit zero always reads one
// R6 - Fields are unsigned, leftmost bit most significant
// R7 - Access time low bits give time unit
// R8 - Bits six to three hold multiplier code
// R9 - Clocked access time counts hundreds of cycles
// R10 - Host adds async and clocked access parts
// R11 - Transfer rate low bits give rate unit
// R12 - Twelve-bit command class support mask
// R13 - Read block length is power of two
// R14 - Partial read flag permits short blocks
// R15 - Write cross boundary flag permits crossing
// R16 - Three five-bit erase and protect geometry fields
// R17 - Protect enable, speed, write length fixed
// R18 - Four three-bit current codes, bits 61-50
// R19 - Host recomputes checksum after programming
// R20 - Read cross boundary flag permits crossing
// R21 - Reserved bits zero, writes altering read-only bits refused
`default_nettype none
package csdr_pkg;

    // =========================================================
    // Register width and field positions
    // =========================================================
    localparam int unsigned CSDR_WIDTH          = 128;  // Whole register
    localparam int unsigned CSDR_STRUCT_MSB     = 127;  // Structure version
    localparam int unsigned CSDR_STRUCT_LSB     = 126;
    localparam int unsigned CSDR_SPEC_MSB       = 125;  // Spec version code
    localparam int unsigned CSDR_SPEC_LSB       = 122;
    localparam int unsigned CSDR_RSV0_MSB       = 121;  // Reserved
    localparam int unsigned CSDR_RSV0_LSB       = 120;
    localparam int unsigned CSDR_ASYNC_ACCESS_TIME_MSB       = 119;  // Async access time
    localparam int unsigned CSDR_ASYNC_ACCESS_TIME_LSB       = 112;
    localparam int unsigned CSDR_CLOCKED_ACCESS_TIME_MSB       = 111;  // Clocked access time
    localparam int unsigned CSDR_CLOCKED_ACCESS_TIME_LSB       = 104;
    localparam int unsigned CSDR_RATE_MSB       = 103;  // Max transfer rate
    localparam int unsigned CSDR_RATE_LSB       = 96;
    localparam int unsigned CSDR_CCC_MSB        = 95;   // Command class mask
    localparam int unsigned CSDR_CCC_LSB        = 84;
    localparam int unsigned CSDR_RBL_MSB        = 83;   // Read block length
    localparam int unsigned CSDR_RBL_LSB        = 80;
    localparam int unsigned CSDR_RPART_BIT      = 79;   // Partial read allowed
    localparam int unsigned CSDR_WMIS_BIT       = 78;   // Write cross boundary
    localparam int unsigned CSDR_RMIS_BIT       = 77;   // Read cross boundary
    localparam int unsigned CSDR_RSV1_MSB       = 75;   // Reserved
    localparam int unsigned CSDR_RSV1_LSB       = 74;
    localparam int unsigned CSDR_CUR_MSB        = 61;   // Current codes
    localparam int unsigned CSDR_CUR_LSB        = 50;
    localparam int unsigned CSDR_EUS_MSB        = 46;   // Erase unit size
    localparam int unsigned CSDR_EUS_LSB        = 42;
    localparam int unsigned CSDR_EUM_MSB        = 41;   // Erase unit multiplier
    localparam int unsigned CSDR_EUM_LSB        = 37;
    localparam int unsigned CSDR_PGS_MSB        = 36;   // Protect group size
    localparam int unsigned CSDR_PGS_LSB        = 32;
    localparam int unsigned CSDR_PGE_BIT        = 31;   // Protect group enable
    localparam int unsigned CSDR_WBL_MSB        = 25;   // Write block length
    localparam int unsigned CSDR_WBL_LSB        = 22;
    localparam int unsigned CSDR_WPART_BIT      = 21;   // Partial write allowed
    localparam int unsigned CSDR_RSV2_MSB       = 20;   // Reserved
    localparam int unsigned CSDR_RSV2_LSB       = 16;
    localparam int unsigned CSDR_FLG_BIT        = 15;   // File layout group
    localparam int unsigned CSDR_COPY_BIT       = 14;   // Copy flag
    localparam int unsigned CSDR_PERM_BIT       = 13;   // Permanent lock
    localparam int unsigned CSDR_TEMP_BIT       = 12;   // Temporary lock
    localparam int unsigned CSDR_FFMT_MSB       = 11;   // File format
    localparam int unsigned CSDR_FFMT_LSB       = 10;
    localparam int unsigned CSDR_ECC_MSB        = 9;    // Ecc code
    localparam int unsigned CSDR_ECC_LSB        = 8;
    localparam int unsigned CSDR_CRC_MSB        = 7;    // Checksum
    localparam int unsigned CSDR_CRC_LSB        = 1;
    localparam int unsigned CSDR_ONE_BIT        = 0;    // Always one

    // =========================================================
    // Cell masks
    // =========================================================
    // Cells that may be rewritten many times
    localparam logic [127:0] CSDR_MULTI_MASK = 128'h0000_0000_0000_0000_0000_0000_0000_13fe;
    // Cells that may be written once
    localparam logic [127:0] CSDR_ONCE_MASK  = 128'h0000_0000_0000_0000_0000_0000_0000_ec00;
    // Reserved positions, always zero
    localparam logic [127:0] CSDR_RSV_MASK   = 128'h0300_0000_0000_0c00_0000_0000_001f_0000;
    // Reserved top bit of the rate and async access time bytes
    localparam logic [127:0] CSDR_BYTE7_MASK = 128'h0080_0080_0000_0000_0000_0000_0000_0000;
    // Constant one in bit zero
    localparam logic [127:0] CSDR_ONE_MASK   = 128'h0000_0000_0000_0000_0000_0000_0000_0001;

    // =========================================================
    // Reset values
    // =========================================================
    localparam logic [127:0] CSDR_RESET_IMAGE = 128'h0000_0000_0000_0000_0000_0000_0000_0001;
    localparam logic [127:0] CSDR_NO_WRITTEN  = 128'h0;

    // =========================================================
    // Timing and unit constants
    // =========================================================
    localparam int unsigned CSDR_CLOCKED_ACCESS_TIME_UNIT_CYC  = 100;    // Cycles per clocked unit
    localparam int unsigned CSDR_CLOCKED_ACCESS_TIME_MAX_CYC   = 25500;  // Largest clocked delay
    localparam int unsigned CSDR_CLK_PERIOD_PS  = 5000;   // Reference clock period

    // =========================================================
    // Types
    // =========================================================
    // Program command from the command decoder
    typedef struct packed {
        logic         valid;  // One-cycle program request
        logic [127:0] data;   // New register image
    } csdr_prog_t;

    // Decoded control flags used by the card core
    typedef struct packed {
        logic       partial_read_allowed;
        logic       partial_write_allowed;
        logic       write_cross_boundary_ok;
        logic       read_cross_boundary_ok;
        logic       permanent_lock;
        logic       temporary_lock;
        logic [3:0] max_read_block_length;
        logic [3:0] max_write_block_length;
        logic [7:0] clocked_access_time;
    } csdr_flags_t;

    // Result of a program attempt
    typedef enum logic [1:0] {
        CSDR_ST_IDLE,
        CSDR_ST_OK,
        CSDR_ST_REFUSED
    } csdr_status_t;

endpackage : csdr_pkg
`default_nettype wire

/* File: verif/csdr_card_specific_data_chk.sv */
// Purpose : Port-level checks of the card specific data register
// Assumes : One clock domain, program answer one cycle after take
// Notes   : Bound to every instance of the register
`timescale 1ns/1ps
`default_nettype none
module csdr_card_specific_data_chk
    import csdr_pkg::*;
(
    input wire logic         ref_clk,
    input wire logic         arst_n,
    input wire csdr_prog_t   prog,
    input wire logic [127:0] csd_value,
    input wire csdr_flags_t  flags,
    input wire logic [15:0]  nac_max_cyc,
    input wire logic         prog_done,
    input wire logic         prog_error
);
    // Fixed cells: everything but programmable cells and bit zero
    localparam logic [127:0] FIX_M = ~(CSDR_MULTI_MASK | CSDR_ONCE_MASK | CSDR_ONE_MASK);
    logic spent_r;  // Once cells spent after first accepted program
    // =========================================================
    // Helper state
    // =========================================================
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) spent_r <= 1'b0;
        else if (prog_done) spent_r <= 1'b1;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // Isolated request, nothing in flight
    sequence s_take; prog.valid && !$past(prog.valid) && !prog_done; endsequence
    sequence s_accept; prog.valid ##1 prog_done; endsequence
    a_answer_once: assert property (prog.valid |=> prog_done != prog_error)
        else $error("program request not answered once");
    a_no_stray: assert property (!prog.valid |=> !prog_done && !prog_error)
        else $error("stray program answer");
    a_write_lands: assert property (
        s_accept |=> csd_value == ($past(prog.data, 2) | CSDR_ONE_MASK))
        else $error("accepted image not shown");
    a_refuse_keeps: assert property (prog_error |=> $stable(csd_value))
        else $error("refused program altered register");
    a_bit0_one: assert property (csd_value[0])
        else $error("bit zero not one");
    a_rsv_zero: assert property ((csd_value & (CSDR_RSV_MASK | CSDR_BYTE7_MASK)) == '0)
        else $error("reserved bit set");
    a_nac_scale: assert property (nac_max_cyc == 16'(csd_value[111:104]) * 16'd100)
        else $error("clocked access bound wrong");
    a_flags_map: assert property (
        flags == {csd_value[79], csd_value[21], csd_value[78], csd_value[77], csd_value[13],
        csd_value[12], csd_value[83:80], csd_value[25:22], csd_value[111:104]})
        else $error("flags do not match register");
    a_fixed_held: assert property (
        $past(arst_n, 2) |-> $stable(csd_value & FIX_M))
        else $error("fixed cell changed");
    a_fixed_refuse: assert property (
        s_take ##0 ((prog.data ^ csd_value) & FIX_M) != '0 |=> prog_error)
        else $error("fixed cell change not refused");
    a_once_spent: assert property (
        s_take ##0 (spent_r && ((prog.data ^ csd_value) & CSDR_ONCE_MASK) != '0) |=> prog_error)
        else $error("second once write not refused");
endmodule : csdr_card_specific_data_chk
bind csdr_card_specific_data csdr_card_specific_data_chk u_chk (.ref_clk(ref_clk), .arst_n(arst_n),
    .prog(prog), .csd_value(csd_value), .flags(flags), .nac_max_cyc(nac_max_cyc),
    .prog_done(prog_done), .prog_error(prog_error));
`default_nettype wire

/* File: verif/csdr_host_model.sv */
// Purpose : Host side that issues program commands
// Assumes : One-cycle request, or held for back to back commands
// Notes   : Data shows the inverse once the request is released
`timescale 1ns/1ps
`default_nettype none
module csdr_host_model
    import csdr_pkg::*;
(
    input wire logic        ref_clk,
    output var csdr_prog_t  prog
);
    initial prog = '0;
    // Seven-bit checksum over bits 127 to 8, leftmost first
    function automatic logic [6:0] crc7(input logic [127:0] d);
        logic [6:0] c;
        logic       fb;
        c = 7'h00;
        for (int i = 127; i >= 8; i--) begin
            fb = d[i] ^ c[6];
            c = {c[5:0], 1'b0} ^ {3'h0, fb, 2'h0, fb};
        end
        return c;
    endfunction : crc7
    // Whole read delay in cycles: async time rounded up at this clock plus clocked part
    function automatic longint unsigned access_cycles(input logic [127:0] img);
        // Multiplier codes in tenths, code zero reserved
        int unsigned     tenths [16] = '{0, 10, 12, 13, 15, 20, 25, 30, 35, 40, 45, 50, 55, 60, 70, 80};
        longint unsigned ps;
        ps = 64'(tenths[img[118:115]]) * 64'd100;
        for (int i = 0; i < int'(img[114:112]); i++) begin
            ps = ps * 64'd10;
        end
        return (ps + CSDR_CLK_PERIOD_PS - 1) / CSDR_CLK_PERIOD_PS
            + 64'(img[111:104]) * CSDR_CLOCKED_ACCESS_TIME_UNIT_CYC;
    endfunction : access_cycles
    // Send a whole image with fresh checksum; hold keeps the request up
    task automatic send(input logic [127:0] img, input logic hold);
        @(posedge ref_clk);
        prog <= '{valid: 1'b1, data: {img[127:8], crc7(img), img[0]}};
        if (!hold) begin
            @(posedge ref_clk);
            prog <= '{valid: 1'b0, data: ~img};
        end
    endtask : send
endmodule : csdr_host_model
`default_nettype wire

/* File: verif/test_card_specific_data_register.sv */
// Purpose : Self-checking bench of the card specific data register
// Assumes : Answer one cycle after take, contents one cycle later
// Notes   : Expected images come from the cell masks and field slices
`timescale 1ns/1ps
`default_nettype none
module test_card_specific_data_register
    import csdr_pkg::*;
;
    // Arbitrary fixed content with reserved bits set on purpose
    localparam logic [127:0] FIX = 128'hf7e6_d5c4_b3a2_9180_7f6e_5d4c_3b2a_1908;
    localparam logic [127:0] VIEW0 = (FIX & ~(CSDR_RSV_MASK | CSDR_BYTE7_MASK | CSDR_MULTI_MASK
        | CSDR_ONCE_MASK)) | CSDR_ONE_MASK;
    logic         ref_clk = 1'b0;
    logic         arst_n  = 1'b0;
    csdr_prog_t   prog;
    logic [127:0] csd_value;
    csdr_flags_t  flags;
    logic [15:0]  nac_max_cyc;
    logic         prog_done;
    logic         prog_error;
    int           error_cnt = 0;
    int           tests_run = 0;
    logic [127:0] cur;      // Expected register view
    always #2.5 ref_clk = ~ref_clk;
    csdr_card_specific_data #(.FIXED_IMAGE(FIX)) dut (.ref_clk(ref_clk), .arst_n(arst_n),
        .prog(prog), .csd_value(csd_value), .flags(flags), .nac_max_cyc(nac_max_cyc),
        .prog_done(prog_done), .prog_error(prog_error));
    csdr_host_model u_host (.ref_clk(ref_clk), .prog(prog));
    // =========================================================
    // Shared tasks
    // =========================================================
    function automatic logic [127:0] landed(input logic [127:0] img);
        return {img[127:8], u_host.crc7(img), 1'b1};
    endfunction : landed
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    // Whole view, decoded flags and access bound against cur
    task automatic check_view();
        check(csd_value, cur);
        check(128'(flags), 128'({cur[79], cur[21], cur[78], cur[77], cur[13], cur[12], cur[83:80],
            cur[25:22], cur[111:104]}));
        check(128'(nac_max_cyc), 128'(cur[111:104]) * 128'd100);
    endtask : check_view
    task automatic do_prog(input logic [127:0] img, input logic ok);
        u_host.send(img, 1'b0);
        #1;
        check(128'({prog_done, prog_error}), 128'({ok, !ok}));
        @(posedge ref_clk);
        #1;
        if (ok) cur = landed(img);
        check_view();
    endtask : do_prog
    // =========================================================
    // Scenarios
    // =========================================================
    task automatic t_fixed();
        int unsigned bits [8] = '{127, 123, 120, 119, 84, 76, 31, 17};
        foreach (bits[i]) do_prog(cur ^ (128'h1 << bits[i]), 1'b0);
    endtask : t_fixed
    task automatic t_once();
        do_prog((cur | CSDR_ONCE_MASK) & ~CSDR_ONE_MASK, 1'b1);
        do_prog(cur ^ (128'h1 << 14), 1'b0);
        do_prog(cur ^ 128'h1300, 1'b1);
    endtask : t_once
    // Two requests on consecutive edges
    task automatic t_b2b();
        logic [127:0] a;
        logic [127:0] b;
        a = cur ^ 128'h1000;
        b = landed(a) ^ 128'h0100;
        u_host.send(a, 1'b1);
        u_host.send(b, 1'b0);
        #1;
        check(128'({prog_done, prog_error}), 128'h2);
        check(csd_value, landed(a));
        @(posedge ref_clk);
        #1;
        cur = landed(b);
        check_view();
    endtask : t_b2b
    // Watchdog far beyond the expected run
    initial begin
        repeat (3000) @(posedge ref_clk);
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        check(csd_value, CSDR_ONE_MASK);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        cur = VIEW0;
        check_view();
        // Unit 1 ms, multiplier 5.5, clocked code 213 at 5 ns per cycle
        check(128'(u_host.access_cycles(csd_value)), 128'h111c14);
        t_fixed();
        t_once();
        t_b2b();
        give_verdict();
    end
endmodule : test_card_specific_data_register
`default_nettype wire
